// >>> rtl/dbd_pkg.sv
// Purpose: shared constants and carriers for the debug board area decoder
// Assumes: area zero byte addresses are 26 bits wide; pclk runs at 25 MHz
// Notes: window bounds are base plus size; apb offsets are byte addresses
package dbd_pkg;

  // area zero address width and windows
  localparam int ADDR_W = 26;
  localparam logic [25:0] WIN_4M = 26'h0400000;     // eprom, network and led windows
  localparam logic [25:0] WIN_16M = 26'h1000000;    // flash window
  // boot select jumper open
  localparam logic [25:0] OPEN_FLASH_BASE = 26'h0000000;
  localparam logic [25:0] OPEN_EPROM_BASE = 26'h1000000;
  localparam logic [25:0] OPEN_NET_BASE = 26'h1400000;
  localparam logic [25:0] OPEN_LED_BASE = 26'h1800000;
  // boot select jumper shorted
  localparam logic [25:0] SHORT_EPROM_BASE = 26'h0000000;
  localparam logic [25:0] SHORT_NET_BASE = 26'h0400000;
  localparam logic [25:0] SHORT_LED_BASE = 26'h0800000;
  localparam logic [25:0] SHORT_FLASH_BASE = 26'h1000000;

  // led latch reset value: all dark
  localparam logic [7:0] LED_RESET = 8'hff;

  // power button hold times
  localparam int CLK_KHZ = 25000;
  localparam int T_ON_MS = 500;
  localparam int T_OFF_MS = 2000;
  localparam int ON_CYCLES = T_ON_MS * CLK_KHZ;
  localparam int OFF_CYCLES = T_OFF_MS * CLK_KHZ;

  // apb register map
  localparam logic [11:0] CTRL_OFS = 12'h000;
  localparam logic [11:0] STATUS_OFS = 12'h004;
  localparam int CTRL_SOFT_OFF_BIT = 0;
  localparam int ST_POWER_BIT = 0;
  localparam int ST_BUTTON_BIT = 1;
  localparam int ST_BOOT_BIT = 2;
  localparam int ST_ROUTE_LSB = 3;
  localparam int ST_LED_LSB = 8;

  // one area zero request from the host bus
  typedef struct packed {
    logic [25:0] addr;
    logic rd;
    logic wr;
    logic [7:0] data;
  } dbd_req_t;

  // device selects
  typedef struct packed {
    logic flash;
    logic eprom;
    logic netctl;
    logic led_wr;
  } dbd_sel_t;

endpackage : dbd_pkg

// >>> rtl/dbd_hold_timer.sv
// Purpose: counts consecutive cycles of a held level and pulses once at a length
// Assumes: run is synchronous to pclk
// Notes: count restarts whenever run drops
`timescale 1ns/10ps
module dbd_hold_timer #(
  parameter int N = 4
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic run,
  output logic hit
);

  logic [31:0] cnt_q; // held cycles, saturates at n
  logic [31:0] cnt_d;

  // next count: clear when released, saturate at n
  always_comb begin
    if (!run) begin
      cnt_d = 32'h0;
    end else if (cnt_q == 32'(N)) begin
      cnt_d = cnt_q;
    end else begin
      cnt_d = cnt_q + 32'h1;
    end
  end

  // count register
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_q <= 32'h0;
    end else begin
      cnt_q <= cnt_d;
    end
  end

  // pulse on the n-th held cycle, only once per hold
  assign hit = run && (cnt_q == 32'(N - 1));

endmodule : dbd_hold_timer

// >>> rtl/dbd_decoder.sv
// Purpose: area zero decode, led latch, interrupt routing and power button for the debug board
// Assumes: area zero strobes are synchronous to pclk; apb master per amba rules
// Notes: all selects and outputs are registered, one cycle after the request
`timescale 1ns/10ps
// Behaviour
// - jumper open: flash at zero, first 16MB
// - jumper open: eprom window at 0x01000000
// - jumper open: network controller at 0x01400000
// - jumper open: led latch at 0x01800000
// - jumper shorted: eprom at 0 to 0x003fffff
// - jumper shorted: network controller at 0x00400000
// - jumper shorted: led latch at 0x00800000
// - jumper shorted: flash at 0x01000000 to 0x01ffffff
// - led latch takes low data byte
// - zero lights led, one darkens it
// - led window writes latch, reads eprom
// - four jumpers route network irq independently
// - power on after 0.5s, off after 2s
module dbd_decoder #(
  parameter int ON_CYCLES = dbd_pkg::ON_CYCLES,
  parameter int OFF_CYCLES = dbd_pkg::OFF_CYCLES
) (
  input wire logic pclk,
  input wire logic presetn,
  // area zero host bus
  input wire dbd_pkg::dbd_req_t a0_req,
  output dbd_pkg::dbd_sel_t sel_q,
  output logic [7:0] led_n_q,
  // jumpers and interrupts
  input wire logic boot_select_jumper,
  input wire logic irq0_route_jumper,
  input wire logic irq1_route_jumper,
  input wire logic irq2_route_jumper,
  input wire logic irq3_route_jumper,
  input wire logic net_irq,
  output logic [3:0] ext_irq_q,
  // power button
  input wire logic power_button,
  output logic power_on_q,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata_q,
  output logic pready_q,
  output logic pslverr_q
);

  // window hit test
  function automatic logic in_win(input logic [25:0] a, input logic [25:0] base, input logic [25:0] size);
    in_win = (a >= base) && ((a - base) < size);
  endfunction : in_win

  dbd_pkg::dbd_sel_t sel_d; // decoded selects
  logic [7:0] led_n_d; // next led latch
  logic [3:0] ext_irq_d; // routed interrupt
  logic [3:0] route; // route jumpers as a vector
  logic access; // a strobe is active
  logic in_flash, in_eprom, in_net, in_led; // window hits for the current jumper setting

  assign route = {irq3_route_jumper, irq2_route_jumper, irq1_route_jumper, irq0_route_jumper};
  assign access = a0_req.rd || a0_req.wr;

  // window hits, chosen by the boot select jumper
  always_comb begin
    if (boot_select_jumper) begin
      in_eprom = in_win(a0_req.addr, dbd_pkg::SHORT_EPROM_BASE, dbd_pkg::WIN_4M);
      in_net = in_win(a0_req.addr, dbd_pkg::SHORT_NET_BASE, dbd_pkg::WIN_4M);
      in_led = in_win(a0_req.addr, dbd_pkg::SHORT_LED_BASE, dbd_pkg::WIN_4M);
      in_flash = in_win(a0_req.addr, dbd_pkg::SHORT_FLASH_BASE, dbd_pkg::WIN_16M);
    end else begin
      in_flash = in_win(a0_req.addr, dbd_pkg::OPEN_FLASH_BASE, dbd_pkg::WIN_16M);
      in_eprom = in_win(a0_req.addr, dbd_pkg::OPEN_EPROM_BASE, dbd_pkg::WIN_4M);
      in_net = in_win(a0_req.addr, dbd_pkg::OPEN_NET_BASE, dbd_pkg::WIN_4M);
      in_led = in_win(a0_req.addr, dbd_pkg::OPEN_LED_BASE, dbd_pkg::WIN_4M);
    end
  end

  // selects, led latch and irq routing next values
  always_comb begin
    sel_d = '0;
    led_n_d = led_n_q;
    if (access) begin
      sel_d.flash = in_flash;
      sel_d.netctl = in_net;
      // led window reads go to the eprom, writes go to the latch
      sel_d.eprom = in_eprom || (in_led && a0_req.rd);
      sel_d.led_wr = in_led && a0_req.wr;
      if (in_led && a0_req.wr) begin
        led_n_d = a0_req.data;
      end
    end
    ext_irq_d = route & {4{net_irq}};
  end

  // decode registers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sel_q <= '0;
      led_n_q <= dbd_pkg::LED_RESET;
      ext_irq_q <= 4'h0;
    end else begin
      sel_q <= sel_d;
      led_n_q <= led_n_d;
      ext_irq_q <= ext_irq_d;
    end
  end

  // ---------------- power button ----------------
  logic on_hit, off_hit; // hold timer pulses
  logic armed_q, armed_d; // button released since power came on
  logic power_on_d;
  logic soft_off; // software power-off request

  // on timer runs only while off
  dbd_hold_timer #(.N(ON_CYCLES)) u_on_timer (
    .pclk(pclk),
    .presetn(presetn),
    .run(power_button && !power_on_q),
    .hit(on_hit)
  );

  // off timer needs a fresh press so the turn-on press cannot also turn off
  dbd_hold_timer #(.N(OFF_CYCLES)) u_off_timer (
    .pclk(pclk),
    .presetn(presetn),
    .run(power_button && power_on_q && armed_q),
    .hit(off_hit)
  );

  // power state next values
  always_comb begin
    power_on_d = power_on_q;
    armed_d = power_on_q && (armed_q || !power_button);
    if (!power_on_q && on_hit) begin
      power_on_d = 1'b1;
      armed_d = 1'b0;
    end else if (power_on_q && (off_hit || soft_off)) begin
      power_on_d = 1'b0;
      armed_d = 1'b0;
    end
  end

  // power state registers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      power_on_q <= 1'b0;
      armed_q <= 1'b0;
    end else begin
      power_on_q <= power_on_d;
      armed_q <= armed_d;
    end
  end

  // ---------------- apb slave ----------------
  logic pready_d, pslverr_d;
  logic [31:0] prdata_d;
  logic done; // access completes at this edge
  logic [31:0] status; // live status word

  assign done = psel && penable && pready_q;
  assign soft_off = done && pwrite && (paddr == dbd_pkg::CTRL_OFS) && pwdata[dbd_pkg::CTRL_SOFT_OFF_BIT];

  // status word assembly
  always_comb begin
    status = 32'h0;
    status[dbd_pkg::ST_POWER_BIT] = power_on_q;
    status[dbd_pkg::ST_BUTTON_BIT] = power_button;
    status[dbd_pkg::ST_BOOT_BIT] = boot_select_jumper;
    status[dbd_pkg::ST_ROUTE_LSB +: 4] = route;
    status[dbd_pkg::ST_LED_LSB +: 8] = led_n_q;
  end

  // one wait state: ready rises in the second access cycle
  always_comb begin
    pready_d = psel && penable && !pready_q;
    prdata_d = prdata_q;
    pslverr_d = 1'b0;
    if (pready_d) begin
      prdata_d = 32'h0;
      // control reads back as zero, its bit is self clearing
      if (paddr == dbd_pkg::STATUS_OFS) begin
        prdata_d = status;
      end else if (paddr != dbd_pkg::CTRL_OFS) begin
        pslverr_d = 1'b1;
      end
    end
  end

  // apb answer registers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_q <= 1'b0;
      pslverr_q <= 1'b0;
      prdata_q <= 32'h0;
    end else begin
      pready_q <= pready_d;
      pslverr_q <= pslverr_d;
      prdata_q <= prdata_d;
    end
  end

  // ---------------- checks ----------------
  property p_flash_open;
    @(posedge pclk) disable iff (!presetn)
    (a0_req.rd && !boot_select_jumper && a0_req.addr < 26'h1000000) |=> sel_q.flash;
  endproperty
  a_flash_open: assert property (p_flash_open) else $error("flash not selected, jumper open");

  property p_eprom_open;
    @(posedge pclk) disable iff (!presetn)
    (a0_req.rd && !boot_select_jumper && a0_req.addr >= 26'h1000000 && a0_req.addr < 26'h1400000)
      |=> sel_q.eprom && !sel_q.flash;
  endproperty
  a_eprom_open: assert property (p_eprom_open) else $error("eprom not selected, jumper open");

  property p_net_open;
    @(posedge pclk) disable iff (!presetn)
    (a0_req.wr && !boot_select_jumper && a0_req.addr >= 26'h1400000 && a0_req.addr < 26'h1800000)
      |=> sel_q.netctl && !sel_q.led_wr;
  endproperty
  a_net_open: assert property (p_net_open) else $error("network not selected, jumper open");

  property p_led_open;
    @(posedge pclk) disable iff (!presetn)
    (a0_req.wr && !boot_select_jumper && a0_req.addr >= 26'h1800000 && a0_req.addr < 26'h1c00000)
      |=> led_n_q == $past(a0_req.data) && sel_q.led_wr;
  endproperty
  a_led_open: assert property (p_led_open) else $error("led latch missed write, jumper open");

  property p_eprom_short;
    @(posedge pclk) disable iff (!presetn)
    (a0_req.rd && boot_select_jumper && a0_req.addr < 26'h0400000) |=> sel_q.eprom && !sel_q.flash;
  endproperty
  a_eprom_short: assert property (p_eprom_short) else $error("eprom not selected, jumper shorted");

  property p_net_short;
    @(posedge pclk) disable iff (!presetn)
    (a0_req.rd && boot_select_jumper && a0_req.addr >= 26'h0400000 && a0_req.addr < 26'h0800000)
      |=> sel_q.netctl;
  endproperty
  a_net_short: assert property (p_net_short) else $error("network not selected, jumper shorted");

  property p_led_short;
    @(posedge pclk) disable iff (!presetn)
    (a0_req.wr && boot_select_jumper && a0_req.addr >= 26'h0800000 && a0_req.addr < 26'h0c00000)
      |=> led_n_q == $past(a0_req.data);
  endproperty
  a_led_short: assert property (p_led_short) else $error("led latch missed write, jumper shorted");

  property p_flash_short;
    @(posedge pclk) disable iff (!presetn)
    (a0_req.rd && boot_select_jumper && a0_req.addr >= 26'h1000000 && a0_req.addr < 26'h2000000)
      |=> sel_q.flash && !sel_q.eprom;
  endproperty
  a_flash_short: assert property (p_flash_short) else $error("flash not moved, jumper shorted");

  property p_led_read;
    @(posedge pclk) disable iff (!presetn)
    (a0_req.rd && !a0_req.wr && in_led) |=> sel_q.eprom && !sel_q.led_wr && $stable(led_n_q);
  endproperty
  a_led_read: assert property (p_led_read) else $error("led window read not sent to eprom");

  property p_led_hold;
    @(posedge pclk) disable iff (!presetn)
    !(a0_req.wr && in_led) |=> $stable(led_n_q);
  endproperty
  a_led_hold: assert property (p_led_hold) else $error("led latch changed without write");

  property p_irq_route;
    @(posedge pclk) disable iff (!presetn)
    1'b1 |=> ext_irq_q == ($past(route) & {4{$past(net_irq)}});
  endproperty
  a_irq_route: assert property (p_irq_route) else $error("interrupt routing wrong");

  property p_power_on;
    @(posedge pclk) disable iff (!presetn)
    $rose(power_on_q) |-> $past(power_button) && $past(on_hit);
  endproperty
  a_power_on: assert property (p_power_on) else $error("power came on without a full hold");

  property p_unmapped;
    @(posedge pclk) disable iff (!presetn)
    (!in_flash && !in_eprom && !in_net && !in_led) |=> sel_q == '0;
  endproperty
  a_unmapped: assert property (p_unmapped) else $error("unmapped address selected a device");

  // a write in the led window must reach the latch and never select the eprom
  property p_led_write;
    @(posedge pclk) disable iff (!presetn)
    (a0_req.wr && !a0_req.rd && in_led) |=> sel_q.led_wr && !sel_q.eprom;
  endproperty
  a_led_write: assert property (p_led_write) else $error("led window write sent to eprom");

  // power only drops after a full long hold or a software request
  property p_power_off;
    @(posedge pclk) disable iff (!presetn)
    $fell(power_on_q) |-> $past(off_hit) || $past(soft_off);
  endproperty
  a_power_off: assert property (p_power_off) else $error("power went off without a full hold");

endmodule : dbd_decoder

// >>> tb/dbd_host_model.sv
// Purpose: host bus model for area zero, one request at a time
// Assumes: requests launch just after a rising edge of pclk
// Notes: a released bus drops both strobes and shows inverted last address and data, never stale ones
`timescale 1ns/10ps
module dbd_host_model (
  input wire logic pclk,
  output dbd_pkg::dbd_req_t req
);
  // bus idle before the first request
  initial begin
    req = '0;
  end

  // hold one request for a single sampled edge, then release the lines
  task automatic access(input logic [25:0] a, input logic r, input logic w, input logic [7:0] d);
    @(posedge pclk);
    req <= '{addr: a, rd: r, wr: w, data: d};
    @(posedge pclk);
    req <= '{addr: ~a, rd: 1'b0, wr: 1'b0, data: ~d};
  endtask : access
endmodule : dbd_host_model

// >>> tb/tb_top.sv
// Purpose: self-checking bench for the debug board area decoder
// Assumes: short hold counts of 5 and 20 cycles stand in for 0.5 s and 2 s
// Notes: expected selects come from the window table in exp_sel
`timescale 1ns/10ps
module tb_top;
  localparam int ON_N = 5; // turn-on hold, cycles
  localparam int OFF_N = 20; // turn-off hold, cycles
  logic pclk, presetn, boot_select_jumper, net_irq, power_button, power_on_q;
  logic irq0_route_jumper, irq1_route_jumper, irq2_route_jumper, irq3_route_jumper;
  logic psel, penable, pwrite, pready_q, pslverr_q, r, rd_err;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata_q, rd_data;
  logic [7:0] led_n_q, led_exp, d;
  logic [3:0] ext_irq_q, rt;
  logic [25:0] a;
  dbd_pkg::dbd_req_t a0_req;
  dbd_pkg::dbd_sel_t sel_q, s;
  int failures, n_compared;
  // window edges tried under both jumper settings
  logic [25:0] corner [18] = '{26'h0, 26'h03fffff, 26'h0400000, 26'h07fffff, 26'h0800000, 26'h0bfffff,
    26'h0c00000, 26'h0ffffff, 26'h1000000, 26'h13fffff, 26'h1400000, 26'h17fffff, 26'h1800000,
    26'h1bfffff, 26'h1c00000, 26'h1ffffff, 26'h2000000, 26'h3ffffff};

  dbd_host_model host (.pclk, .req(a0_req));
  dbd_decoder #(.ON_CYCLES(ON_N), .OFF_CYCLES(OFF_N)) DUT (.pclk, .presetn, .a0_req, .sel_q, .led_n_q,
    .boot_select_jumper, .irq0_route_jumper, .irq1_route_jumper, .irq2_route_jumper, .irq3_route_jumper,
    .net_irq, .ext_irq_q, .power_button, .power_on_q, .psel, .penable, .pwrite, .paddr, .pwdata,
    .prdata_q, .pready_q, .pslverr_q);

  // 25 MHz clock
  initial begin
    pclk = 1'b0;
    forever #20 pclk = ~pclk;
  end

  // expected selects for one request
  function automatic dbd_pkg::dbd_sel_t exp_sel(input logic [25:0] x, input logic j, input logic rr,
    input logic w);
    dbd_pkg::dbd_sel_t e;
    logic led;
    e = '0;
    led = j ? (x >= 26'h0800000 && x < 26'h0c00000) : (x >= 26'h1800000 && x < 26'h1c00000);
    if (j) begin
      e.eprom = x < 26'h0400000;
      e.netctl = x >= 26'h0400000 && x < 26'h0800000;
      e.flash = x >= 26'h1000000 && x < 26'h2000000;
    end else begin
      e.flash = x < 26'h1000000;
      e.eprom = x >= 26'h1000000 && x < 26'h1400000;
      e.netctl = x >= 26'h1400000 && x < 26'h1800000;
    end
    // led window: reads go to the eprom, writes to the latch
    e.eprom = e.eprom | (led & rr);
    e.led_wr = led & w;
    return e;
  endfunction : exp_sel

  // one comparison, counted
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      failures++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  // counts and verdict, ends the run
  task automatic final_report();
    $display("compared %0d mismatches %0d", n_compared, failures);
    if (failures == 0 && n_compared > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : final_report

  // one apb transfer, waits for pready under a bound
  task automatic apb(input logic w, input logic [11:0] ad, input logic [31:0] wd, output logic [31:0] q,
    output logic e);
    int i;
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= ad;
    pwdata <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    for (i = 0; i < 16; i++) begin
      @(posedge pclk);
      if (pready_q === 1'b1) break;
    end
    if (i == 16) begin
      failures++;
      final_report();
    end else begin
      q = prdata_q;
      e = pslverr_q;
      psel <= 1'b0;
      penable <= 1'b0;
    end
  endtask : apb

  // hold the button for n sampled edges, then release
  task automatic press(input int n);
    @(posedge pclk);
    power_button <= 1'b1;
    repeat (n - 1) @(posedge pclk);
    @(posedge pclk);
    power_button <= 1'b0;
    repeat (2) @(posedge pclk);
    @(negedge pclk);
  endtask : press

  // main sequence
  initial begin
    presetn = 1'b0;
    {boot_select_jumper, net_irq, power_button, psel, penable, pwrite} = '0;
    {irq3_route_jumper, irq2_route_jumper, irq1_route_jumper, irq0_route_jumper} = 4'h1;
    paddr = '0;
    pwdata = '0;
    failures = 0;
    n_compared = 0;
    led_exp = 8'hff;
    void'($urandom(10));
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    @(negedge pclk);
    chk({28'h0, sel_q}, 32'h0);
    chk(32'(led_n_q), 32'hff);
    chk(32'(power_on_q), 32'h0);
    chk(32'({pready_q, pslverr_q}), 32'h0);
    chk(prdata_q, 32'h0);
    $display("reset test done");
    // decode under both jumper settings, edges then random addresses
    for (int j = 0; j < 2; j++) begin
      @(posedge pclk);
      boot_select_jumper <= j[0];
      for (int k = 0; k < 60; k++) begin
        a = (k < 18) ? corner[k] : 26'($urandom());
        r = 1'($urandom());
        d = 8'($urandom());
        host.access(a, r, ~r, d);
        @(negedge pclk);
        s = exp_sel(a, j[0], r, ~r);
        if (s.led_wr) led_exp = d;
        chk({28'h0, sel_q}, {28'h0, s});
        chk(32'(led_n_q), 32'(led_exp));
      end
    end
    $display("decode test done");
    // interrupt routing with random jumpers
    for (int k = 0; k < 24; k++) begin
      @(posedge pclk);
      {irq3_route_jumper, irq2_route_jumper, irq1_route_jumper, irq0_route_jumper, net_irq} <= 5'($urandom());
      @(posedge pclk);
      @(negedge pclk);
      rt = {irq3_route_jumper, irq2_route_jumper, irq1_route_jumper, irq0_route_jumper};
      chk(32'(ext_irq_q), 32'(rt & {4{net_irq}}));
    end
    $display("interrupt test done");
    // hold times at their edges; the turn-on press never turns off
    press(ON_N - 1);
    chk(32'(power_on_q), 32'h0);
    press(OFF_N + 3);
    chk(32'(power_on_q), 32'h1);
    press(OFF_N - 1);
    chk(32'(power_on_q), 32'h1);
    press(OFF_N);
    chk(32'(power_on_q), 32'h0);
    press(ON_N);
    chk(32'(power_on_q), 32'h1);
    $display("power test done");
    // status, control readback, unmapped offsets, software power-off
    apb(1'b0, 12'h004, 32'h0, rd_data, rd_err);
    chk(rd_data, {16'h0, led_exp, 1'b0, irq3_route_jumper, irq2_route_jumper, irq1_route_jumper,
      irq0_route_jumper, boot_select_jumper, 2'b01});
    chk(32'(rd_err), 32'h0);
    apb(1'b0, 12'h000, 32'h0, rd_data, rd_err);
    chk(rd_data, 32'h0);
    chk(32'(rd_err), 32'h0);
    apb(1'b0, 12'h008, 32'h0, rd_data, rd_err);
    chk(rd_data, 32'h0);
    chk(32'(rd_err), 32'h1);
    apb(1'b1, 12'h00c, 32'h1, rd_data, rd_err);
    chk(32'(rd_err), 32'h1);
    chk(32'(power_on_q), 32'h1);
    apb(1'b1, 12'h000, 32'h1, rd_data, rd_err);
    repeat (2) @(posedge pclk);
    @(negedge pclk);
    chk(32'(power_on_q), 32'h0);
    $display("register test done");
    // reset in mid-run while powered, then a latch write right after release
    press(ON_N);
    chk(32'(power_on_q), 32'h1);
    @(posedge pclk);
    presetn <= 1'b0;
    @(negedge pclk);
    chk(32'({led_n_q, power_on_q}), 32'h1fe);
    @(posedge pclk);
    presetn <= 1'b1;
    led_exp = 8'h3c;
    host.access(26'h0800000, 1'b0, 1'b1, led_exp);
    @(negedge pclk);
    chk(32'(led_n_q), 32'(led_exp));
    $display("mid-run reset test done");
    final_report();
  end
endmodule : tb_top
